// ==== lmq_cfg.svh ====
// register offsets, reset values and field layout for the queue config bank
`ifndef LMQ_CFG_SVH
`define LMQ_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LMQ_OFF_DEV_FEAT      12'h010
`define LMQ_OFF_DEV_FEAT_SEL  12'h014
`define LMQ_OFF_DRV_FEAT      12'h020
`define LMQ_OFF_DRV_FEAT_SEL  12'h024
`define LMQ_OFF_PAGE_BYTES    12'h028
`define LMQ_OFF_QUEUE_SEL     12'h030
`define LMQ_OFF_QUEUE_LIMIT   12'h034
`define LMQ_OFF_QUEUE_SIZE    12'h038
`define LMQ_OFF_USED_ALIGN    12'h03c
`define LMQ_OFF_PAGE_FRAME    12'h040
`define LMQ_OFF_QUEUE_KICK    12'h050
`define LMQ_OFF_INT_CAUSE     12'h060
`define LMQ_OFF_INT_ACK       12'h064
`define LMQ_OFF_STATUS        12'h070
// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define LMQ_ZERO_WORD         32'h0000_0000
`define LMQ_ZERO_ADDR         64'h0000_0000_0000_0000
`define LMQ_INT_USED_BIT      0
`define LMQ_INT_CONFIG_BIT    1
`define LMQ_INT_DEFINED_MASK  32'h0000_0003
`endif

// ==== lmq_pkg.sv ====
// shared types for the queue config bank
`default_nettype none
package lmq_pkg;
    // one register access from driver software
    typedef struct packed {
        logic        wr;      // write strobe
        logic        rd;      // read strobe
        logic [11:0] addr;    // byte offset
        logic [31:0] wdata;   // write data
    } lmq_req_t;
    // settings of one queue, as seen by the ring engine
    typedef struct packed {
        logic        active;  // page frame nonzero
        logic [31:0] size;    // element count in use
        logic [31:0] align;   // used ring alignment, bytes
        logic [31:0] frame;   // page frame number
        logic [63:0] base;    // guest address of first page
    } lmq_qinfo_t;
endpackage
`default_nettype wire

// ==== lmq_regs.sv ====
// legacy memory-mapped queue configuration register bank
// ----------------------------------------------------------------
// Notes on behaviour
// - queue base is page size times frame
// - queue select steers per-queue registers
// - queue indices start at zero
// - size limit reads max or zero
// - size write records selected queue count
// - alignment write records selected queue boundary
// - frame write gives descriptor table page
// - frame read returns page, nonzero active
// - frame accesses follow selected queue
// - device feature select picks read word
// - driver feature write records activated flags
// - driver feature select picks written word
// - status zero write resets, clears frames
// - kick write signals queue has buffers
// - interrupt line high while cause set
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "lmq_cfg.svh"

module lmq_regs #(
    parameter int NUM_QUEUES = 8,    // queues the device offers
    parameter int FEAT_WORDS = 2,    // 32-bit feature words
    parameter int QUEUE_MAX  = 256   // largest element count
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // register access from driver
    input  wire lmq_pkg::lmq_req_t            req,
    output logic [31:0]                       rdata,
    output logic                              rvalid,
    // feature words
    input  wire logic [FEAT_WORDS*32-1:0]     dev_features,
    output logic [FEAT_WORDS*32-1:0]          drv_features,
    // device events
    input  wire logic                         ev_used,
    input  wire logic                         ev_config,
    output logic                              irq,
    // queue kick and device reset
    output logic                              kick_valid,
    output logic [31:0]                       kick_index,
    output logic                              dev_reset,
    // ring engine lookup
    input  wire logic [31:0]                  qry_index,
    output lmq_pkg::lmq_qinfo_t               qry_info
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic        wr;           // write this cycle
    logic        rd;           // read this cycle
    logic        soft_rst;     // status zero write
    logic [31:0] dev_sel;      // device feature word select
    logic [31:0] drv_sel;      // driver feature word select
    logic [31:0] page_bytes;   // guest page size in bytes
    logic [31:0] queue_sel;    // selected queue index
    logic [31:0] int_cause;    // sticky interrupt causes
    logic        sel_ok;       // selected queue exists
    logic        qry_ok;       // looked-up queue exists

    // per-queue storage, one word each
    // written through the select; lookup reads all three, bus reads only the frame
    logic [31:0] q_size  [NUM_QUEUES];
    logic [31:0] q_align [NUM_QUEUES];
    logic [31:0] q_frame [NUM_QUEUES];

    // strobes are one-cycle pulses; wr and rd never together
    assign wr = req.wr;
    assign rd = req.rd;

    // status itself lives elsewhere; only its zero write is seen here
    assign soft_rst = wr && (req.addr == `LMQ_OFF_STATUS)
                      && (req.wdata == `LMQ_ZERO_WORD);

    // queue numbers count up from zero; beyond the last is unmapped
    assign sel_ok = (queue_sel < NUM_QUEUES);
    assign qry_ok = (qry_index < NUM_QUEUES);

    // ------------------------------------------------------------
    // global registers
    // ------------------------------------------------------------
    // feature selects, page size and queue select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // power-on: every select at zero, no page size yet
            dev_sel    <= `LMQ_ZERO_WORD;
            drv_sel    <= `LMQ_ZERO_WORD;
            page_bytes <= `LMQ_ZERO_WORD;
            queue_sel  <= `LMQ_ZERO_WORD;
        end else if (soft_rst) begin
            // device reset returns all setup to power-on values
            dev_sel    <= `LMQ_ZERO_WORD;
            drv_sel    <= `LMQ_ZERO_WORD;
            page_bytes <= `LMQ_ZERO_WORD;
            queue_sel  <= `LMQ_ZERO_WORD;
        end else if (wr) begin
            // plain writes; other offsets leave these alone
            if (req.addr == `LMQ_OFF_DEV_FEAT_SEL) begin
                // picks which offered word a feature read shows
                dev_sel <= req.wdata;
            end else if (req.addr == `LMQ_OFF_DRV_FEAT_SEL) begin
                // picks which activated word the next write fills
                drv_sel <= req.wdata;
            end else if (req.addr == `LMQ_OFF_PAGE_BYTES) begin
                // stored as written; power of two is the driver's job
                page_bytes <= req.wdata;
            end else if (req.addr == `LMQ_OFF_QUEUE_SEL) begin
                // out-of-range index kept; per-queue access then idles
                queue_sel <= req.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // driver feature words
    // ------------------------------------------------------------
    // a write while the select is out of range lands nowhere
    genvar gf;
    generate
        for (gf = 0; gf < FEAT_WORDS; gf++) begin : g_feat
            // one activated-flag word per select value
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    // no feature active until the driver writes it
                    drv_features[gf*32 +: 32] <= `LMQ_ZERO_WORD;
                end else if (soft_rst) begin
                    // soft reset drops every activated flag
                    drv_features[gf*32 +: 32] <= `LMQ_ZERO_WORD;
                end else if (wr && req.addr == `LMQ_OFF_DRV_FEAT
                             && drv_sel == gf) begin
                    drv_features[gf*32 +: 32] <= req.wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // per-queue registers
    // ------------------------------------------------------------
    genvar gq;
    generate
        for (gq = 0; gq < NUM_QUEUES; gq++) begin : g_queue
            // an out-of-range select matches no entry at all
            logic hit;   // this queue is the selected one
            assign hit = wr && sel_ok && (queue_sel == gq);

            // size, alignment and page frame of one queue
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    // every queue starts idle, frame zero
                    q_size[gq]  <= `LMQ_ZERO_WORD;
                    q_align[gq] <= `LMQ_ZERO_WORD;
                    q_frame[gq] <= `LMQ_ZERO_WORD;
                end else if (soft_rst) begin
                    // every queue is stopped by the reset
                    q_size[gq]  <= `LMQ_ZERO_WORD;
                    q_align[gq] <= `LMQ_ZERO_WORD;
                    q_frame[gq] <= `LMQ_ZERO_WORD;
                end else if (hit) begin
                    // only the per-queue offsets are decoded here
                    if (req.addr == `LMQ_OFF_QUEUE_SIZE) begin
                        // not checked against the limit; driver's duty
                        q_size[gq] <= req.wdata;
                    end else if (req.addr == `LMQ_OFF_USED_ALIGN) begin
                        // power of two assumed, not enforced
                        q_align[gq] <= req.wdata;
                    end else if (req.addr == `LMQ_OFF_PAGE_FRAME) begin
                        // a zero write is how the driver stops a queue
                        q_frame[gq] <= req.wdata;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt causes
    // ------------------------------------------------------------
    logic [31:0] ev_bits;   // events arriving this cycle
    logic [31:0] ack_bits;  // bits the driver acknowledges

    // map event pulses to their cause bits
    // bit positions come from the shared config header
    always_comb begin
        ev_bits = `LMQ_ZERO_WORD;
        ev_bits[`LMQ_INT_USED_BIT]   = ev_used;
        ev_bits[`LMQ_INT_CONFIG_BIT] = ev_config;
    end

    // ack clears only the ones written; zeros leave bits alone
    assign ack_bits = (wr && req.addr == `LMQ_OFF_INT_ACK) ?
                      req.wdata : `LMQ_ZERO_WORD;

    // sticky causes; a new event beats an ack in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_cause <= `LMQ_ZERO_WORD;
        end else if (soft_rst) begin
            // events of the reset cycle are kept, old ones dropped
            int_cause <= ev_bits;
        end else begin
            // undefined bits are masked, so they never read as set
            int_cause <= ((int_cause & ~ack_bits) | ev_bits)
                         & `LMQ_INT_DEFINED_MASK;
        end
    end

    // one shared line, level while any defined cause is pending
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // line quiet while in reset
            irq <= 1'b0;
        end else begin
            // registered, so the line trails its cause bit by a cycle
            irq <= |(int_cause & `LMQ_INT_DEFINED_MASK);
        end
    end

    // ------------------------------------------------------------
    // kick and reset pulses
    // ------------------------------------------------------------
    // one-cycle pulse carrying the kicked queue number
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // no kick pending after power-on
            kick_valid <= 1'b0;
            kick_index <= `LMQ_ZERO_WORD;
        end else begin
            kick_valid <= wr && (req.addr == `LMQ_OFF_QUEUE_KICK);
            if (wr && req.addr == `LMQ_OFF_QUEUE_KICK) begin
                // index passed on unchecked; the ring engine filters it
                // and it holds between kicks for a late reader
                kick_index <= req.wdata;
            end
        end
    end

    // tells the rest of the device to drop its ring state
    // one cycle is enough; the ring engine acts on the pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dev_reset <= 1'b0;
        end else begin
            dev_reset <= soft_rst;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [31:0] next_rdata;   // word for the current read
    logic [31:0] dev_word;     // selected device feature word

    // an out-of-range select reads as no features at all
    // the loop unrolls into a small mux over the offered words
    always_comb begin
        dev_word = `LMQ_ZERO_WORD;
        for (int i = 0; i < FEAT_WORDS; i++) begin
            if (dev_sel == i) begin
                dev_word = dev_features[i*32 +: 32];
            end
        end
    end

    // only readable registers return data; all else reads as zero
    always_comb begin
        next_rdata = `LMQ_ZERO_WORD;
        if (req.addr == `LMQ_OFF_DEV_FEAT) begin
            // word chosen by the last select write
            next_rdata = dev_word;
        end else if (req.addr == `LMQ_OFF_QUEUE_LIMIT) begin
            // missing queue reports zero so the driver skips it
            if (sel_ok) begin
                next_rdata = 32'(QUEUE_MAX);
            end
        end else if (req.addr == `LMQ_OFF_PAGE_FRAME) begin
            // nonzero frame means the queue is in use
            if (sel_ok) begin
                next_rdata = q_frame[queue_sel];
            end
        end else if (req.addr == `LMQ_OFF_INT_CAUSE) begin
            // reading does not clear; only an ack write or a soft reset does
            next_rdata = int_cause;
        end
    end

    // read data registered, answered one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata  <= `LMQ_ZERO_WORD;
            rvalid <= 1'b0;
        end else begin
            // every read is answered, mapped offset or not
            rvalid <= rd;
            // held between reads, so late sampling is safe
            if (rd) begin
                rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // ring engine lookup
    // ------------------------------------------------------------
    lmq_pkg::lmq_qinfo_t next_info;   // combinational lookup

    // base address is frame times page size, full 64-bit product
    always_comb begin
        // a missing queue looks idle with every field zero
        next_info = '0;
        if (qry_ok) begin
            // 32 by 32 bits cannot overflow the 64-bit base
            next_info.frame  = q_frame[qry_index];
            next_info.size   = q_size[qry_index];
            next_info.align  = q_align[qry_index];
            next_info.active = (q_frame[qry_index] != `LMQ_ZERO_WORD);
            next_info.base   = {32'h0000_0000, q_frame[qry_index]}
                               * {32'h0000_0000, page_bytes};
        end
    end

    // registered so the multiplier sits in one cycle on its own
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qry_info <= '0;
        end else begin
            // result trails qry_index by one clock
            qry_info <= next_info;
        end
    end

endmodule
`default_nettype wire

// ==== lmq_regs_chk.sv ====
// assertion checker bound to the queue config register bank
`timescale 1ns/1ps
`default_nettype none
module lmq_regs_chk #(
    parameter int NUM_QUEUES = 8,    // queues offered
    parameter int FEAT_WORDS = 2,    // 32-bit feature words
    parameter int QUEUE_MAX  = 256   // element limit
) (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     rst,
    // register access
    input wire lmq_pkg::lmq_req_t        req,
    input wire logic [31:0]              rdata,
    input wire logic                     rvalid,
    // features and events
    input wire logic [FEAT_WORDS*32-1:0] dev_features,
    input wire logic [FEAT_WORDS*32-1:0] drv_features,
    input wire logic                     ev_used,
    input wire logic                     ev_config,
    input wire logic                     irq,
    // kick, reset and lookup
    input wire logic                     kick_valid,
    input wire logic [31:0]              kick_index,
    input wire logic                     dev_reset,
    input wire logic [31:0]              qry_index,
    input wire lmq_pkg::lmq_qinfo_t      qry_info
);
    // ----------------------------------------------------------------
    // helper terms and sequences
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic kick_wr;  // write to the kick register
    logic zero_st;  // zero write to status, soft reset
    logic any_ev;   // either event input
    assign kick_wr = req.wr && req.addr == 12'h050;
    assign zero_st = req.wr && req.addr == 12'h070 && req.wdata == 32'h0;
    assign any_ev = ev_used || ev_config;
    // a soft reset right after the event drops the cause; irq still reads high at the check and falls a cycle later
    sequence ev_s; any_ev ##1 !zero_st; endsequence
    sequence wo_rd_s;
        req.rd && req.addr inside {12'h014, 12'h020, 12'h024, 12'h028,
                                   12'h030, 12'h038, 12'h03c, 12'h050};
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    rd_answer_a: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    rd_only_a: assert property (!req.rd |=> !rvalid)
        else $error("answer without read");
    wo_zero_a: assert property (wo_rd_s |=> rdata == 32'h0)
        else $error("write-only register read nonzero");
    kick_fwd_a: assert property (
        kick_wr |=> kick_valid && kick_index == $past(req.wdata))
        else $error("kick not forwarded");
    kick_only_a: assert property (!kick_wr |=> !kick_valid)
        else $error("kick without write");
    irq_set_a: assert property (ev_s |=> irq)
        else $error("event left irq low");
    irq_cause_a: assert property ($rose(irq) |-> $past(any_ev, 2))
        else $error("irq rose without event");
    sreset_a: assert property (zero_st |=> dev_reset)
        else $error("soft reset missing");
    sreset_only_a: assert property (!zero_st |=> !dev_reset)
        else $error("soft reset without zero write");
    frame_clr_a: assert property (
        dev_reset |=> qry_info.frame == 32'h0 && !qry_info.active)
        else $error("frame kept over soft reset");
    active_flag_a: assert property (
        qry_info.active == (qry_info.frame != 32'h0))
        else $error("active flag disagrees with frame");
    feat_hold_a: assert property (
        !(req.wr && req.addr == 12'h020) && !zero_st |=> $stable(drv_features))
        else $error("driver flags changed without write");
endmodule
bind lmq_regs lmq_regs_chk #(
    .NUM_QUEUES(NUM_QUEUES), .FEAT_WORDS(FEAT_WORDS), .QUEUE_MAX(QUEUE_MAX)
) chk_u (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .dev_features(dev_features), .drv_features(drv_features),
    .ev_used(ev_used), .ev_config(ev_config), .irq(irq),
    .kick_valid(kick_valid), .kick_index(kick_index),
    .dev_reset(dev_reset), .qry_index(qry_index), .qry_info(qry_info));
`default_nettype wire

// ==== lmq_regs_tb.sv ====
// self-checking bench for the queue config register bank
`timescale 1ns/1ps
`default_nettype none
module lmq_regs_tb;
    // ----------------------------------------------------------------
    // signals and design
    // ----------------------------------------------------------------
    localparam int NQ = 8;                // queues in this build
    logic                clk;             // 10 MHz clock
    logic                rst;             // async reset
    logic                ev_used;         // used buffer event
    logic                ev_config;       // config change event
    lmq_pkg::lmq_req_t   req;             // register access
    logic [63:0]         dev_features;    // offered flags
    logic [31:0]         qry_index;       // lookup queue
    logic [31:0]         rdata;           // read word
    logic [31:0]         kick_index;      // kicked queue
    logic                rvalid;          // read answer
    logic                irq;             // interrupt line
    logic                kick_valid;      // kick pulse
    logic                dev_reset;       // soft reset pulse
    logic [63:0]         drv_features;    // activated flags
    lmq_pkg::lmq_qinfo_t qry_info;        // lookup result
    int                  n_fail = 0;      // mismatches
    int                  n_compared = 0;  // comparisons
    int                  cycles = 0;      // run length
    lmq_regs #(.NUM_QUEUES(NQ), .FEAT_WORDS(2), .QUEUE_MAX(256)) dut_u (
        .clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .dev_features(dev_features), .drv_features(drv_features),
        .ev_used(ev_used), .ev_config(ev_config), .irq(irq),
        .kick_valid(kick_valid), .kick_index(kick_index),
        .dev_reset(dev_reset), .qry_index(qry_index), .qry_info(qry_info));
    // ----------------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [160:0] got, input logic [160:0] exp,
                       input string msg);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    // one access; strobes drop a cycle later, so never reassigned at once
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(negedge clk);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk({rvalid, rdata}, {1'b1, e}, "read data");
    endtask
    task automatic complete_run();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_feat();
        for (int w = 0; w < 3; w++) begin
            acc(1'b1, 12'h014, w);
            rd(12'h010, w < 2 ? dev_features[w*32+:32] : 32'h0);
        end
        acc(1'b1, 12'h024, 32'h1);
        acc(1'b1, 12'h020, 32'hcafe_0001);
        acc(1'b1, 12'h024, 32'h0);
        acc(1'b1, 12'h020, 32'h0000_00f5);
        chk(drv_features, 64'hcafe_0001_0000_00f5, "driver flags");
        $display("test features done");
    endtask
    // last index is one past the end: writes ignored, reads zero
    task automatic t_queues();
        acc(1'b1, 12'h028, 32'h1000);
        for (int q = 0; q <= NQ; q++) begin
            acc(1'b1, 12'h030, q);
            rd(12'h034, q < NQ ? 32'h100 : 32'h0);
            acc(1'b1, 12'h038, 16 + q);
            acc(1'b1, 12'h03c, 4 << q);
            acc(1'b1, 12'h040, 32 + q);
        end
        for (int q = NQ; q >= 0; q--) begin
            acc(1'b1, 12'h030, q);
            rd(12'h040, q < NQ ? 32 + q : 32'h0);
            qry_index = q;
            @(negedge clk);
            chk(qry_info, q < NQ ? {1'b1, 32'(16 + q), 32'(4 << q),
                32'(32 + q), 64'((32 + q) * 4096)} : 161'h0, "lookup");
        end
        $display("test queues done");
    endtask
    task automatic t_wo();
        logic [11:0] wo [8] = '{12'h014, 12'h020, 12'h024, 12'h028,
                                12'h030, 12'h038, 12'h03c, 12'h050};
        foreach (wo[i]) rd(wo[i], 32'h0);
        acc(1'b1, 12'h030, 32'h0);
        acc(1'b1, 12'h040, 32'h0);
        rd(12'h040, 32'h0);
        acc(1'b1, 12'h034, 32'h5);
        rd(12'h034, 32'h100);
        $display("test access kinds done");
    endtask
    task automatic t_kick();
        acc(1'b1, 12'h050, 32'h5);
        chk({kick_valid, kick_index}, {1'b1, 32'h5}, "kick");
        @(negedge clk);
        chk(kick_valid, 1'b0, "kick pulse length");
        $display("test kick done");
    endtask
    task automatic t_irq();
        rd(12'h060, 32'h0);
        ev_used = 1'b1;
        @(negedge clk);
        ev_used = 1'b0;
        @(negedge clk);
        chk(irq, 1'b1, "irq on used event");
        ev_config = 1'b1;
        @(negedge clk);
        ev_config = 1'b0;
        acc(1'b1, 12'h060, 32'h0);
        rd(12'h060, 32'h3);
        acc(1'b1, 12'h064, 32'h1);
        rd(12'h060, 32'h2);
        acc(1'b1, 12'h064, 32'h2);
        @(negedge clk);
        chk(irq, 1'b0, "irq after ack");
        $display("test interrupt done");
    endtask
    task automatic t_soft();
        qry_index = 32'h2;
        acc(1'b1, 12'h030, 32'h2);
        acc(1'b1, 12'h040, 32'h77);
        acc(1'b1, 12'h070, 32'h1);
        chk(dev_reset, 1'b0, "nonzero status write");
        rd(12'h040, 32'h77);
        chk(qry_info, {1'b1, 32'h12, 32'h10, 32'h77, 64'h7_7000},
            "lookup before reset");
        acc(1'b1, 12'h070, 32'h0);
        chk(dev_reset, 1'b1, "soft reset pulse");
        acc(1'b1, 12'h030, 32'h2);
        rd(12'h040, 32'h0);
        chk(drv_features, 64'h0, "flags cleared");
        chk(qry_info, 161'h0, "lookup cleared");
        $display("test soft reset done");
    endtask
    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        rst = 1'b1;
        req = '0;
        ev_used = 1'b0;
        ev_config = 1'b0;
        qry_index = 32'h0;
        dev_features = 64'h1234_5678_9abc_def0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_feat();
        t_queues();
        t_wo();
        t_kick();
        t_irq();
        t_soft();
        complete_run();
    end
endmodule
`default_nettype wire
